// File: hw/fmt_regs.sv
// Fault suppress, frequency trim and soft-start register bank
`timescale 1ns/1ps
`default_nettype none
`include "fmt_regs_map.svh"
// Summary of operation
// - Four bits suppress per-string open faults
// - Backlight raise bit lifts frequency 8.5%
// - Backlight lower bit drops frequency 8.5%
// - TFT raise bit lifts frequency 8.5%
// - TFT lower bit drops frequency 8.5%
// - Boost undervoltage suppress bit blocks pin
// - Boost overvoltage suppress bit blocks pin
// - Short-to-ground suppress bit blocks pin
// - Input undervoltage suppress bit blocks pin
// - Soft-start select: 50 ms or 22 ms
// - Negative output undervoltage suppress blocks pin
// - Positive gate undervoltage suppress blocks pin
// - Negative gate undervoltage suppress blocks pin
// - Thermal warning suppress bit blocks pin
// - Open flag means string open, disabled
// - Thermal warning flag set at 125 C
module fmt_regs (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Fault flags from the supervisors
    input wire logic [3:0] led_open_flag_in,
    input wire logic boost_uv_flag_in,
    input wire logic boost_ov_flag_in,
    input wire logic short_gnd_flag_in,
    input wire logic hvinp_uv_flag_in,
    input wire logic neg_uv_flag_in,
    input wire logic gvdd_uv_flag_in,
    input wire logic gvee_uv_flag_in,
    input wire logic junction_hot_in,
    // Status flags seen by software
    output logic [3:0] led_open_flag_out,
    output logic backlight_thermal_warning_flag_out,
    // Fault pin, active low
    output logic fault_output_pin_n_out,
    // Converter controls
    output logic backlight_freq_raise_out,
    output logic backlight_freq_lower_out,
    output logic tft_freq_raise_out,
    output logic tft_freq_lower_out,
    output logic fast_soft_start_out
);
    fmt_pkg::fmt_byte_t bl_q;
    fmt_pkg::fmt_byte_t tft_q;
    logic therm_q;
    fmt_pkg::fmt_byte_t rdata_d;
    fmt_pkg::fmt_string_t open_live;
    logic fault_any_d;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            bl_q <= `FMT_RST_BL;
            tft_q <= `FMT_RST_TFT;
            therm_q <= `FMT_RST_THERM;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `FMT_OFS_BL_SUPPRESS_TRIM) begin
                bl_q <= reg_wdata_in;
            end else if (reg_addr_in == `FMT_OFS_TFT_SUPPRESS) begin
                tft_q <= reg_wdata_in;
            end else if (reg_addr_in == `FMT_OFS_THERM_SUPPRESS) begin
                therm_q <= reg_wdata_in[`FMT_THERM_WARN];
            end
        end
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = `FMT_RD_UNMAPPED;
        if (reg_addr_in == `FMT_OFS_BL_SUPPRESS_TRIM) begin
            rdata_d = bl_q;
        end else if (reg_addr_in == `FMT_OFS_TFT_SUPPRESS) begin
            rdata_d = tft_q;
        end else if (reg_addr_in == `FMT_OFS_THERM_SUPPRESS) begin
            // Only one bit is implemented; the rest read zero
            rdata_d = `FMT_RD_UNMAPPED;
            rdata_d[`FMT_THERM_WARN] = therm_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------------
    assign open_live = led_open_flag_in;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            led_open_flag_out <= 4'h0;
            backlight_thermal_warning_flag_out <= 1'b0;
        end else begin
            led_open_flag_out <= open_live;
            backlight_thermal_warning_flag_out <= junction_hot_in;
        end
    end

    // ---------------------------------------------------------------
    // Fault pin
    // ---------------------------------------------------------------
    always_comb begin
        fault_any_d = |(open_live & ~bl_q[`FMT_BL_OPEN_HI:`FMT_BL_OPEN_LO]);
        fault_any_d = fault_any_d | (boost_uv_flag_in & ~tft_q[`FMT_TFT_BOOST_UV]);
        fault_any_d = fault_any_d | (boost_ov_flag_in & ~tft_q[`FMT_TFT_BOOST_OV]);
        fault_any_d = fault_any_d | (short_gnd_flag_in & ~tft_q[`FMT_TFT_SHORT_GND]);
        fault_any_d = fault_any_d | (hvinp_uv_flag_in & ~tft_q[`FMT_TFT_HVINP_UV]);
        fault_any_d = fault_any_d | (neg_uv_flag_in & ~tft_q[`FMT_TFT_NEG_UV]);
        fault_any_d = fault_any_d | (gvdd_uv_flag_in & ~tft_q[`FMT_TFT_GVDD_UV]);
        fault_any_d = fault_any_d | (gvee_uv_flag_in & ~tft_q[`FMT_TFT_GVEE_UV]);
        fault_any_d = fault_any_d | (junction_hot_in & ~therm_q);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fault_output_pin_n_out <= 1'b1;
        end else begin
            fault_output_pin_n_out <= ~fault_any_d;
        end
    end

    // ---------------------------------------------------------------
    // Converter controls
    // ---------------------------------------------------------------
    // Raise and lower together is left to the host to avoid
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            backlight_freq_raise_out <= 1'b0;
            backlight_freq_lower_out <= 1'b0;
            tft_freq_raise_out <= 1'b0;
            tft_freq_lower_out <= 1'b0;
            fast_soft_start_out <= 1'b0;
        end else begin
            backlight_freq_raise_out <= bl_q[`FMT_BL_FREQ_RAISE];
            backlight_freq_lower_out <= bl_q[`FMT_BL_FREQ_LOWER];
            tft_freq_raise_out <= bl_q[`FMT_TFT_FREQ_RAISE];
            tft_freq_lower_out <= bl_q[`FMT_TFT_FREQ_LOWER];
            fast_soft_start_out <= tft_q[`FMT_TFT_SOFT_START];
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    open_suppress_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (led_open_flag_in != 4'h0
         && (led_open_flag_in & ~bl_q[`FMT_BL_OPEN_HI:`FMT_BL_OPEN_LO]) == 4'h0
         && !boost_uv_flag_in && !boost_ov_flag_in && !short_gnd_flag_in && !hvinp_uv_flag_in
         && !neg_uv_flag_in && !gvdd_uv_flag_in && !gvee_uv_flag_in && !junction_hot_in)
        |=> fault_output_pin_n_out)
        else $error("masked open faults drove the fault pin");
    bl_raise_follow_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == `FMT_OFS_BL_SUPPRESS_TRIM
        |-> ##2 backlight_freq_raise_out == $past(reg_wdata_in[3], 2))
        else $error("backlight raise output did not follow write");
    bl_lower_follow_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == `FMT_OFS_BL_SUPPRESS_TRIM
        |-> ##2 backlight_freq_lower_out == $past(reg_wdata_in[2], 2))
        else $error("backlight lower output did not follow write");
    tft_trim_follow_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == `FMT_OFS_BL_SUPPRESS_TRIM
        |-> ##2 (tft_freq_raise_out == $past(reg_wdata_in[1], 2)
                 && tft_freq_lower_out == $past(reg_wdata_in[0], 2)))
        else $error("TFT trim outputs did not follow write");
    soft_start_sel_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == `FMT_OFS_TFT_SUPPRESS
        |-> ##2 fast_soft_start_out == $past(reg_wdata_in[3], 2))
        else $error("soft-start select did not follow write");
    unmasked_fault_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (boost_uv_flag_in && !tft_q[`FMT_TFT_BOOST_UV]) |=> !fault_output_pin_n_out)
        else $error("unmasked boost undervoltage missed the fault pin");
    therm_warn_pin_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (junction_hot_in && !therm_q) |=> !fault_output_pin_n_out)
        else $error("unmasked thermal warning missed the fault pin");
    therm_flag_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        1'b1 |=> backlight_thermal_warning_flag_out == $past(junction_hot_in))
        else $error("thermal warning flag wrong");
    reset_clear_a: assert property (
        @(posedge clk_sys_in)
        rst_in |=> (fault_output_pin_n_out && !fast_soft_start_out
                    && !backlight_freq_raise_out && bl_q == 8'h00 && tft_q == 8'h00))
        else $error("state not cleared by reset");
    therm_readback_a: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        reg_rd_in && reg_addr_in == `FMT_OFS_THERM_SUPPRESS
        |=> reg_rdata_out == {6'h00, $past(therm_q), 1'b0})
        else $error("thermal suppress readback wrong");

endmodule // fmt_regs
`default_nettype wire

// File: inc/fmt_regs_map.svh
// Register offsets, field positions and reset values of the fault mask bank
`ifndef FMT_REGS_MAP_SVH
`define FMT_REGS_MAP_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define FMT_OFS_BL_SUPPRESS_TRIM 8'h0A
`define FMT_OFS_TFT_SUPPRESS 8'h0B
`define FMT_OFS_THERM_SUPPRESS 8'h0C

// ---------------------------------------------------------------
// Fields of the backlight suppress and trim register
// ---------------------------------------------------------------
`define FMT_BL_OPEN_HI 7
`define FMT_BL_OPEN_LO 4
`define FMT_BL_FREQ_RAISE 3
`define FMT_BL_FREQ_LOWER 2
`define FMT_TFT_FREQ_RAISE 1
`define FMT_TFT_FREQ_LOWER 0

// ---------------------------------------------------------------
// Fields of the TFT suppress register
// ---------------------------------------------------------------
`define FMT_TFT_BOOST_UV 7
`define FMT_TFT_BOOST_OV 6
`define FMT_TFT_SHORT_GND 5
`define FMT_TFT_HVINP_UV 4
`define FMT_TFT_SOFT_START 3
`define FMT_TFT_NEG_UV 2
`define FMT_TFT_GVDD_UV 1
`define FMT_TFT_GVEE_UV 0

// ---------------------------------------------------------------
// Fields of the thermal warning suppress register
// ---------------------------------------------------------------
`define FMT_THERM_WARN 1

// ---------------------------------------------------------------
// Reset values and the read value of unmapped addresses and bits
// ---------------------------------------------------------------
`define FMT_RST_BL 8'h00
`define FMT_RST_TFT 8'h00
`define FMT_RST_THERM 1'b0
`define FMT_RD_UNMAPPED 8'h00

`endif

// File: inc/fmt_pkg.sv
// Types shared by the fault mask and frequency trim bank
package fmt_pkg;
    typedef logic [7:0] fmt_byte_t;
    typedef logic [3:0] fmt_string_t;
endpackage

// File: sim/fmt_host_model.sv
// Host model issuing single-byte register accesses to the fault mask bank
`timescale 1ns/1ps
`default_nettype none
module fmt_host_model (
    // Clock
    input wire logic clk_sys_in,
    // Register port towards the bank
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // One strobe cycle, launched and released on falling edges
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = w;
        reg_rd_out = !w;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        // Released lines flip so stale values cannot pass for valid ones
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
endmodule // fmt_host_model
`default_nettype wire

// File: sim/tb_fmt_regs.sv
// Self-checking testbench of the fault mask and trim bank
`timescale 1ns/1ps
`default_nettype none
module tb_fmt_regs;
    logic clk_sys_in;
    logic rst_in;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] rdata;
    logic [11:0] fl;
    logic [3:0] open_q;
    logic warn;
    logic pin_n;
    logic [4:0] ctl;
    logic [7:0] ma;
    fmt_pkg::fmt_byte_t mask_v;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    fmt_host_model fmt_host_model_i (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr),
        .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

    fmt_regs fmt_regs_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .led_open_flag_in(fl[11:8]), .boost_uv_flag_in(fl[7]),
        .boost_ov_flag_in(fl[6]), .short_gnd_flag_in(fl[5]), .hvinp_uv_flag_in(fl[4]),
        .neg_uv_flag_in(fl[3]), .gvdd_uv_flag_in(fl[2]), .gvee_uv_flag_in(fl[1]),
        .junction_hot_in(fl[0]), .led_open_flag_out(open_q),
        .backlight_thermal_warning_flag_out(warn), .fault_output_pin_n_out(pin_n),
        .backlight_freq_raise_out(ctl[4]), .backlight_freq_lower_out(ctl[3]),
        .tft_freq_raise_out(ctl[2]), .tft_freq_lower_out(ctl[1]),
        .fast_soft_start_out(ctl[0]));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        fmt_host_model_i.access(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        fmt_host_model_i.access(a, 8'h00, 1'b0);
        cmp(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs under 150 cycles
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            end_sim;
        end
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        fl = 12'h000;
        tick(5);
        rst_in = 1'b0;
        tick(1);
        rd(8'h0A, 8'h00);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        cmp({2'h0, ctl, pin_n}, 8'h01);
        // Each flag alone pulls the pin, then its own suppress bit releases it
        for (int i = 0; i < 12; i++) begin
            ma = (i > 7) ? 8'h0A : (i > 0) ? 8'h0B : 8'h0C;
            mask_v = (i > 7) ? 8'(8'h01 << (i - 4)) : (i > 3) ? 8'(8'h01 << i) :
                (i > 0) ? 8'(8'h01 << (i - 1)) : 8'h02;
            fl = 12'(12'h001 << i);
            tick(2);
            cmp({7'h00, pin_n}, 8'h00);
            cmp({2'h0, warn, 1'b0, open_q}, {2'h0, fl[0], 1'b0, fl[11:8]});
            wr(ma, mask_v);
            tick(2);
            cmp({7'h00, pin_n}, 8'h01);
            // Flag drops before the mask clears, so no two drives share a time step
            fl = 12'h000;
            wr(ma, 8'h00);
        end
        // Raise and lower of one converter never set together
        for (int b = 0; b < 4; b++) begin
            wr(8'h0A, 8'(8'h01 << b));
            tick(1);
            cmp({3'h0, ctl}, 8'(8'h02 << b));
        end
        wr(8'h0A, 8'h00);
        wr(8'h0B, 8'h08);
        tick(1);
        cmp({3'h0, ctl}, 8'h01);
        rd(8'h0B, 8'h08);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h02);
        wr(8'h0D, 8'hFF);
        rd(8'h0D, 8'h00);
        rd(8'h0A, 8'h00);
        rst_in = 1'b1;
        tick(1);
        rst_in = 1'b0;
        tick(1);
        cmp({2'h0, ctl, pin_n}, 8'h01);
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'h00);
        end_sim;
    end
endmodule // tb_fmt_regs
`default_nettype wire
